// ===== include/attr_pkg.sv
// Constants and carrier types for the accelerometer trim/trigger registers.
// Assumes an 8-bit register port from the serial front end, one clock.
package attr_pkg;
  localparam logic [7:0] ADDR_INIT_TWO  = 8'h28;
  localparam logic [7:0] ADDR_TRIGGERED_SAMPLING_MODE_CNT  = 8'h29;
  localparam logic [7:0] ADDR_X_OFF_LO  = 8'h2a;
  localparam logic [7:0] ADDR_X_OFF_HI  = 8'h2b;
  localparam logic [7:0] ADDR_Y_OFF_LO  = 8'h2c;
  localparam logic [7:0] ADDR_Y_OFF_HI  = 8'h2d;
  localparam logic [7:0] ADDR_Z_OFF_LO  = 8'h2e;
  localparam logic [7:0] ADDR_Z_OFF_HI  = 8'h2f;
  localparam logic [7:0] ADDR_X_GAIN_LO = 8'h30;
  localparam logic [7:0] ADDR_Y_GAIN_LO = 8'h31;
  localparam logic [7:0] ADDR_Z_GAIN_LO = 8'h32;
  localparam logic [7:0] RST_INIT_TWO   = 8'h00;
  localparam logic [7:0] RST_TRIGGERED_SAMPLING_MODE_CNT   = 8'h00;
  localparam logic [7:0] TRIGGERED_SAMPLING_MODE_CONTINUOUS = 8'hff;
  localparam int         GAIN_MSB_POS   = 7;
  localparam int         OFF_HI_W       = 7;
  localparam int         OFF_W          = 15;
  localparam int         GAIN_W         = 9;
  localparam int         GAIN_FRAC      = 8;
  localparam int         ACC_W          = 16;
  // Operating mode field encodings
  localparam logic [2:0] MODE_SLEEP     = 3'h0;
  localparam logic [2:0] MODE_STANDBY   = 3'h1;
  localparam logic [2:0] MODE_SNIFF     = 3'h2;
  localparam logic [2:0] MODE_CONTINUOUS_WAKE_MODE     = 3'h5;
  localparam logic [2:0] MODE_SNIFF_WAKE_MODE     = 3'h6;
  localparam logic [2:0] MODE_TRIGGERED_SAMPLING_MODE      = 3'h7;

  typedef struct packed {
    logic [OFF_W-1:0]  offset;
    logic [GAIN_W-1:0] gain;
  } attr_trim_t;

  typedef struct packed {
    logic [ACC_W-1:0] x;
    logic [ACC_W-1:0] y;
    logic [ACC_W-1:0] z;
  } attr_vec_t;

  typedef enum logic [1:0] {
    ATTR_IDLE  = 2'b00,
    ATTR_COUNT = 2'b01,
    ATTR_CONT  = 2'b10
  } attr_triggered_sampling_mode_state_t;
endpackage

// ===== rtl/attr_axis_cal.sv
// One axis calibration stage: gain scale then signed offset add.
// Assumes raw samples and trim values on the same clock.
`timescale 1ns/1ns
module attr_axis_cal
  import attr_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Sample in
  input  wire logic             valid_i,
  input  wire logic [ACC_W-1:0] raw_i,
  input  wire attr_trim_t       trim_i,
  // Sample out
  output logic      [ACC_W-1:0] cal_o
);
  logic signed [ACC_W+GAIN_W:0] prod;
  logic signed [ACC_W+GAIN_W:0] sum;
  logic        [ACC_W-1:0]      cal_q;

  // Gain is unity at 256, so a 9-bit value spans 0 to about 2x
  assign prod = $signed(raw_i) * $signed({1'b0, trim_i.gain});
  assign sum  = (prod >>> GAIN_FRAC)
              + (ACC_W+GAIN_W+1)'($signed(trim_i.offset));
  assign cal_o = cal_q;

  // Trim is sampled with each sample, so a write counts from the next one
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal_q <= '0;
    end else if (valid_i) begin
      cal_q <= sum[ACC_W-1:0];
    end
  end
endmodule

// ===== rtl/attr_regs.sv
// Trim and one-shot trigger register bank of the accelerometer.
// Assumes the serial front end delivers one-cycle write/read strobes
// on clk_i, and the mode controller supplies the operating mode field.
`timescale 1ns/1ns
module attr_regs
  import attr_pkg::*;
#(
  parameter attr_trim_t X_TRIM_RST = '{offset: 15'h0000, gain: 9'h100},
  parameter attr_trim_t Y_TRIM_RST = '{offset: 15'h0000, gain: 9'h100},
  parameter attr_trim_t Z_TRIM_RST = '{offset: 15'h0000, gain: 9'h100}
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Register port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Factory calibration load
  input  wire logic       cal_load_i,
  input  wire attr_trim_t cal_x_i,
  input  wire attr_trim_t cal_y_i,
  input  wire attr_trim_t cal_z_i,
  // Mode and trigger
  input  wire logic [2:0] operating_mode_field_i,
  input  wire logic       triggered_sampling_mode_start_i,
  input  wire logic       sample_tick_i,
  output logic            sample_req_o,
  output logic            triggered_sampling_mode_busy_o,
  // Acceleration path
  input  wire attr_vec_t  raw_i,
  output attr_vec_t       extended_output_regs_o,
  output logic            ext_valid_o
);
  logic [7:0]       init_word_two_q;
  logic [7:0]       oneshot_sample_count_q;
  attr_trim_t       x_axis_q, y_axis_q, z_axis_q;
  logic [7:0]       rdata_q;
  attr_triggered_sampling_mode_state_t st_q, st_d;
  logic [7:0]       left_q, left_d;
  logic [2:0]       mode_prev_q;
  logic             req_q, valid_q, busy_q;
  attr_vec_t        cal;
  attr_trim_t       x_wr, y_wr, z_wr;

  function automatic attr_trim_t wr_trim(input attr_trim_t cur,
                                         input logic [7:0] a,
                                         input logic [7:0] lo,
                                         input logic [7:0] gl,
                                         input logic [7:0] d);
    attr_trim_t t;
    t = cur;
    if (a == lo) begin
      t.offset[7:0] = d;
    end
    if (a == lo + 8'h01) begin
      t.offset[OFF_W-1:8] = d[OFF_HI_W-1:0];
      t.gain[8] = d[GAIN_MSB_POS];
    end
    if (a == gl) begin
      t.gain[7:0] = d;
    end
    return t;
  endfunction

  wire mode_changed = operating_mode_field_i != mode_prev_q;
  // A zero count is refused, so an idle bank never starts an empty run
  wire triggered_sampling_mode_go      = triggered_sampling_mode_start_i
                   && operating_mode_field_i == MODE_TRIGGERED_SAMPLING_MODE
                   && oneshot_sample_count_q != 8'h00;
  wire last_sample  = sample_tick_i && left_q == 8'h01;
  // A tick that meets a mode change is dropped, the run is over by then
  wire take_sample  = (st_q != ATTR_IDLE) && !mode_changed
                   && sample_tick_i;
  // Plain register write decode
  wire wr_init_two  = reg_wr_i && reg_addr_i == ADDR_INIT_TWO;
  wire wr_triggered_sampling_mode_cnt  = reg_wr_i && reg_addr_i == ADDR_TRIGGERED_SAMPLING_MODE_CNT;

  // Next trim value of each axis if this cycle's write lands on it
  assign x_wr = wr_trim(x_axis_q, reg_addr_i, ADDR_X_OFF_LO,
                        ADDR_X_GAIN_LO, reg_wdata_i);
  assign y_wr = wr_trim(y_axis_q, reg_addr_i, ADDR_Y_OFF_LO,
                        ADDR_Y_GAIN_LO, reg_wdata_i);
  assign z_wr = wr_trim(z_axis_q, reg_addr_i, ADDR_Z_OFF_LO,
                        ADDR_Z_GAIN_LO, reg_wdata_i);

  // Trigger sequencer: count down or run until the mode field moves
  always_comb begin
    st_d   = st_q;
    left_d = left_q;
    case (st_q)
      ATTR_IDLE: begin
        if (triggered_sampling_mode_go) begin
          left_d = oneshot_sample_count_q;
          st_d   = (oneshot_sample_count_q == TRIGGERED_SAMPLING_MODE_CONTINUOUS)
                 ? ATTR_CONT : ATTR_COUNT;
        end
      end
      ATTR_COUNT: begin
        if (mode_changed || last_sample) begin
          st_d = ATTR_IDLE;
        end
        if (sample_tick_i) begin
          left_d = left_q - 8'h01;
        end
      end
      ATTR_CONT: begin
        if (mode_changed) begin
          st_d = ATTR_IDLE;
        end
      end
      default: st_d = ATTR_IDLE;
    endcase
  end

  // Busy has its own flop so the port comes straight from one
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q        <= ATTR_IDLE;
      left_q      <= 8'h00;
      // Sleep differs from a live mode for one cycle only; idle ignores it
      mode_prev_q <= MODE_SLEEP;
      req_q       <= 1'b0;
      valid_q     <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      st_q        <= st_d;
      left_q      <= left_d;
      mode_prev_q <= operating_mode_field_i;
      req_q       <= take_sample;
      valid_q     <= req_q;
      busy_q      <= st_d != ATTR_IDLE;
    end
  end

  // Registers: factory load wins over a same-cycle host write, later host writes replace it
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      init_word_two_q        <= RST_INIT_TWO;
      oneshot_sample_count_q <= RST_TRIGGERED_SAMPLING_MODE_CNT;
      x_axis_q               <= X_TRIM_RST;
      y_axis_q               <= Y_TRIM_RST;
      z_axis_q               <= Z_TRIM_RST;
    end else if (cal_load_i) begin
      // Factory load is a boot-time event; a write in that cycle is lost
      x_axis_q <= cal_x_i;
      y_axis_q <= cal_y_i;
      z_axis_q <= cal_z_i;
    end else if (reg_wr_i) begin
      if (wr_init_two) begin
        init_word_two_q <= reg_wdata_i;
      end
      if (wr_triggered_sampling_mode_cnt) begin
        oneshot_sample_count_q <= reg_wdata_i;
      end
      x_axis_q <= x_wr;
      y_axis_q <= y_wr;
      z_axis_q <= z_wr;
    end
  end

  // Offset-high byte: gain bit 8 on top of offset bits 14 to 8
  function automatic logic [7:0] hi_byte(input attr_trim_t t);
    return {t.gain[GAIN_W-1], t.offset[OFF_W-1:8]};
  endfunction

  // Trim registers read back too, so software can do read-modify-write;
  // unmapped addresses read as zero
  wire [7:0] rd_mux =
      (reg_addr_i == ADDR_INIT_TWO)  ? init_word_two_q :
      (reg_addr_i == ADDR_TRIGGERED_SAMPLING_MODE_CNT)  ? oneshot_sample_count_q :
      (reg_addr_i == ADDR_X_OFF_LO)  ? x_axis_q.offset[7:0] :
      (reg_addr_i == ADDR_X_OFF_HI)  ? hi_byte(x_axis_q) :
      (reg_addr_i == ADDR_Y_OFF_LO)  ? y_axis_q.offset[7:0] :
      (reg_addr_i == ADDR_Y_OFF_HI)  ? hi_byte(y_axis_q) :
      (reg_addr_i == ADDR_Z_OFF_LO)  ? z_axis_q.offset[7:0] :
      (reg_addr_i == ADDR_Z_OFF_HI)  ? hi_byte(z_axis_q) :
      (reg_addr_i == ADDR_X_GAIN_LO) ? x_axis_q.gain[7:0] :
      (reg_addr_i == ADDR_Y_GAIN_LO) ? y_axis_q.gain[7:0] :
      (reg_addr_i == ADDR_Z_GAIN_LO) ? z_axis_q.gain[7:0] : 8'h00;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux;
    end
  end

  // Three identical axis stages share the one request strobe
  attr_axis_cal u_cal_x (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .valid_i   (req_q),
    .raw_i     (raw_i.x),
    .trim_i    (x_axis_q),
    .cal_o     (cal.x)
  );

  attr_axis_cal u_cal_y (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .valid_i   (req_q),
    .raw_i     (raw_i.y),
    .trim_i    (y_axis_q),
    .cal_o     (cal.y)
  );

  attr_axis_cal u_cal_z (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .valid_i   (req_q),
    .raw_i     (raw_i.z),
    .trim_i    (z_axis_q),
    .cal_o     (cal.z)
  );

  assign reg_rdata_o            = rdata_q;
  assign sample_req_o           = req_q;
  assign triggered_sampling_mode_busy_o            = busy_q;
  assign extended_output_regs_o = cal;
  assign ext_valid_o            = valid_q;
endmodule

// ===== testbench/attr_monitor.sv
// Port checker for the trim and trigger register bank.
// Assumes it is bound to attr_regs and sees only its ports.
`timescale 1ns/1ns
module attr_monitor
  import attr_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [2:0] operating_mode_field_i,
  input wire logic       triggered_sampling_mode_start_i,
  input wire logic       sample_tick_i,
  input wire logic       sample_req_o,
  input wire logic       triggered_sampling_mode_busy_o,
  input wire logic       ext_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  req_has_tick_a: assert property (sample_req_o |->
    $past(sample_tick_i && triggered_sampling_mode_busy_o)) else $error("req without tick");
  idle_quiet_a: assert property (!triggered_sampling_mode_busy_o &&
    !$past(triggered_sampling_mode_busy_o) |-> !sample_req_o) else $error("req when idle");
  busy_cause_a: assert property ($rose(triggered_sampling_mode_busy_o) |->
    $past(triggered_sampling_mode_start_i)) else $error("busy without start");
  valid_after_a: assert property (sample_req_o |=>
    ext_valid_o) else $error("no result after req");
  valid_cause_a: assert property (ext_valid_o |->
    $past(sample_req_o)) else $error("result without req");
  mode_stop_a: assert property (triggered_sampling_mode_busy_o &&
    operating_mode_field_i != $past(operating_mode_field_i)
    |-> ##[1:2] !triggered_sampling_mode_busy_o) else $error("run kept after mode change");
  busy_end_a: assert property ($fell(triggered_sampling_mode_busy_o) |->
    sample_req_o || $past(operating_mode_field_i) !=
    $past(operating_mode_field_i, 2)) else $error("run ended early");
  wrong_mode_a: assert property (triggered_sampling_mode_start_i && !triggered_sampling_mode_busy_o &&
    operating_mode_field_i != MODE_TRIGGERED_SAMPLING_MODE |=> !triggered_sampling_mode_busy_o)
    else $error("start taken outside trigger mode");
  hole_read_a: assert property (reg_rd_i && reg_addr_i > 8'h32
    ##1 !reg_rd_i |=> reg_rdata_o == 8'h00) else $error("hole not zero");
endmodule
bind attr_regs attr_monitor i_attr_monitor (.clk_i, .sys_rst_i, .reg_rd_i,
  .reg_addr_i, .reg_rdata_o, .operating_mode_field_i, .triggered_sampling_mode_start_i,
  .sample_tick_i, .sample_req_o, .triggered_sampling_mode_busy_o, .ext_valid_o);

// ===== testbench/attr_host.sv
// Host model: drives the register port of the bank.
// Assumes strobes and data are sampled on the rising edge of clk_i.
`timescale 1ns/1ns
module attr_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial {wr_o, rd_o, addr_o, wdata_o} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i) #1;
    {wr_o, addr_o, wdata_o} = {1'b1, a, v};
    @(posedge clk_i) #1;
    {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~v};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i) #1;
    {rd_o, addr_o} = {1'b1, a};
    @(posedge clk_i) #1;
    {rd_o, addr_o} = {1'b0, ~a};
    @(posedge clk_i) #1 v = rdata_i;
  endtask
  // Shared gain/offset byte: keep bits outside the mask
  task automatic rmw(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] v);
    logic [7:0] t;
    rd(a, t);
    wr(a, (t & ~m) | (v & m));
  endtask
endmodule

// ===== testbench/attr_regs_test.sv
// Bench for the trim and trigger register bank.
// Assumes the host model drives the register port.
`timescale 1ns/1ns
module attr_regs_test
  import attr_pkg::*;
;
  logic       clk_i, sys_rst_i, reg_wr_i, reg_rd_i, cal_load_i;
  logic       triggered_sampling_mode_start_i, sample_tick_i, sample_req_o, triggered_sampling_mode_busy_o;
  logic       ext_valid_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [2:0] operating_mode_field_i;
  attr_trim_t cal_x_i, cal_y_i, cal_z_i;
  attr_vec_t  raw_i, extended_output_regs_o;
  logic [14:0] off [3];
  logic [8:0]  gn [3];
  int          fails, tests_run, n;
  attr_regs i_attr_regs (.clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .cal_load_i, .cal_x_i,
    .cal_y_i, .cal_z_i, .operating_mode_field_i, .triggered_sampling_mode_start_i,
    .sample_tick_i, .sample_req_o, .triggered_sampling_mode_busy_o, .raw_i,
    .extended_output_regs_o, .ext_valid_o);
  attr_host i_attr_host (.clk_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  always #10 clk_i = ~clk_i;
  task automatic chk(string s, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [15:0] cal(logic [15:0] r, int a);
    logic signed [25:0] p;
    p = $signed(r) * $signed({1'b0, gn[a]});
    return p[23:8] + {off[a][14], off[a]};
  endfunction
  task automatic run(input int n, input bit cont);
    int reqs;
    reqs = 0;
    raw_i = 48'({$urandom, $urandom});
    @(posedge clk_i) #1 triggered_sampling_mode_start_i = 1;
    @(posedge clk_i) #1 triggered_sampling_mode_start_i = 0;
    for (int c = 0; c < 1200 && (c < 3 || triggered_sampling_mode_busy_o || sample_req_o
         || ext_valid_o); c++) begin
      @(posedge clk_i) #1;
      reqs += sample_req_o;
      if (ext_valid_o) begin
        chk("x", extended_output_regs_o.x, cal(raw_i.x, 0));
        chk("y", extended_output_regs_o.y, cal(raw_i.y, 1));
        chk("z", extended_output_regs_o.z, cal(raw_i.z, 2));
      end
      if (cont && reqs == n) operating_mode_field_i = MODE_CONTINUOUS_WAKE_MODE;
      sample_tick_i = c % 4 == 0;
    end
    @(posedge clk_i) #1 sample_tick_i = 0;
    operating_mode_field_i = MODE_TRIGGERED_SAMPLING_MODE;
    chk("samples", 16'(reqs), 16'(n));
    chk("run ended", 16'(triggered_sampling_mode_busy_o), 16'h0000);
    if (triggered_sampling_mode_busy_o) results();
    else $display("run of %0d done", n);
  endtask
  initial begin
    {clk_i, triggered_sampling_mode_start_i, sample_tick_i, cal_load_i} = '0;
    {cal_x_i, cal_y_i, cal_z_i, raw_i} = '0;
    {sys_rst_i, fails, tests_run} = '0;
    sys_rst_i = 1;
    operating_mode_field_i = MODE_TRIGGERED_SAMPLING_MODE;
    n = $urandom(32'h2357);
    repeat (8) @(posedge clk_i);
    #1 sys_rst_i = 0;
    i_attr_host.rd(ADDR_TRIGGERED_SAMPLING_MODE_CNT, d);
    chk("count reset", d, 0);
    i_attr_host.rd(ADDR_INIT_TWO, d);
    chk("init reset", d, 0);
    i_attr_host.rd(ADDR_X_OFF_HI, d);
    chk("trim reset", d, 8'h80);
    i_attr_host.wr(ADDR_INIT_TWO, 8'h00);
    i_attr_host.rd(ADDR_INIT_TWO, d);
    chk("init two", d, 0);
    i_attr_host.wr(8'h33, 8'ha5);
    i_attr_host.rd(8'h33, d);
    chk("hole", d, 0);
    cal_x_i = 24'($urandom);
    @(posedge clk_i) #1 cal_load_i = 1;
    @(posedge clk_i) #1 cal_load_i = 0;
    i_attr_host.rd(ADDR_X_GAIN_LO, d);
    chk("factory", d, 8'(cal_x_i.gain));
    for (int a = 0; a < 3; a++) begin
      off[a] = 15'($urandom);
      gn[a] = 9'($urandom);
      i_attr_host.wr(ADDR_X_OFF_LO + 8'(2 * a), off[a][7:0]);
      i_attr_host.rmw(ADDR_X_OFF_HI + 8'(2 * a), 8'h7f, {1'b0, off[a][14:8]});
      i_attr_host.rmw(ADDR_X_OFF_HI + 8'(2 * a), 8'h80, {gn[a][8], 7'h00});
      i_attr_host.wr(ADDR_X_GAIN_LO + 8'(a), gn[a][7:0]);
      i_attr_host.rd(ADDR_X_OFF_HI + 8'(2 * a), d);
      chk("offset high", d, {gn[a][8], off[a][14:8]});
    end
    $display("register tests done");
    for (int i = 0; i < 3; i++) begin
      n = i == 0 ? 1 : i == 1 ? 254 : 2 + $urandom % 252;
      i_attr_host.wr(ADDR_TRIGGERED_SAMPLING_MODE_CNT, 8'(n));
      run(n, 0);
    end
    operating_mode_field_i = MODE_SLEEP;
    @(posedge clk_i) #1 triggered_sampling_mode_start_i = 1;
    @(posedge clk_i) #1 triggered_sampling_mode_start_i = 0;
    @(posedge clk_i) #1 chk("refused", triggered_sampling_mode_busy_o, 0);
    operating_mode_field_i = MODE_TRIGGERED_SAMPLING_MODE;
    i_attr_host.wr(ADDR_TRIGGERED_SAMPLING_MODE_CNT, 8'h00);
    @(posedge clk_i) #1 triggered_sampling_mode_start_i = 1;
    @(posedge clk_i) #1 triggered_sampling_mode_start_i = 0;
    @(posedge clk_i) #1 chk("zero count", triggered_sampling_mode_busy_o, 0);
    $display("refusal tests done");
    i_attr_host.wr(ADDR_TRIGGERED_SAMPLING_MODE_CNT, TRIGGERED_SAMPLING_MODE_CONTINUOUS);
    run(260, 1);
    results();
  end
endmodule
